/* File: rtl/capture_timer_regs.vh */
// Register offsets, field positions, reset values and timing counts of the capture timer
`ifndef CAPTURE_TIMER_REGS_VH
`define CAPTURE_TIMER_REGS_VH
`define ADDR_TIMER_CONTROL      4'h0
`define ADDR_CAPTURE_IO_CONTROL 4'h1
`define ADDR_COUNT_VALUE        4'h2
`define ADDR_GENERAL_A          4'h3
`define ADDR_GENERAL_C_BUFFER   4'h4
`define ADDR_TIMER_FLAGS        4'h5
`define ADDR_SOURCE_ENABLES     4'h6
`define ADDR_TIMER_MODE         4'h7
`define ADDR_INT_LEVEL_CONTROL  4'h8
`define ADDR_COUNT_HIGH         4'h9
`define ADDR_GENERAL_A_HIGH     4'ha
`define ADDR_GENERAL_C_HIGH     4'hb
`define CTL_SRC_LSB             0
`define CTL_EDGE_LSB            3
`define CTL_CLR_LSB             5
`define SRC_OSC_40MHZ           3'h6
`define EXT_EDGE_BOTH           2'h2
`define CLR_DISABLED            2'h0
`define IO_EDGE_LSB             0
`define IO_MODE_BIT             2
`define IO_BUF_BIT              3
`define EDGE_RISING             2'h0
`define EDGE_FALLING            2'h1
`define EDGE_BOTH               2'h2
`define FLAG_CAPT_BIT           0
`define FLAG_OVF_BIT            3
`define IEN_CAPT_BIT            0
`define IEN_OVF_BIT             3
`define MODE_FILTER_BIT         2
`define MODE_FCLK_LSB           4
`define MODE_START_BIT          7
`define FCLK_COUNT_SRC          2'h3
`define IC_REQ_BIT              3
`define RST_CTRL8               8'h00
`define RST_DATA16              16'h0000
`define OSC_PERIOD_NS           25
`define CORE_PERIOD_NS          8
`define OSC_NUM                 (`CORE_PERIOD_NS)
`define FILTER_SAMPLES          3
`define CNT_MAX                 16'hffff
`endif

/* File: rtl/capture_timer.v */
// Sixteen-bit capture timer with channel A input capture and buffered previous value
//
// What this block does
// - Source 110 counts from 40 MHz oscillator
// - External edge 10 counts both edges
// - Clear source 00 never clears counter
// - Edge field 10 captures both edges
// - Mode bit b2 selects input capture
// - Bit b3 makes C buffer A
// - Counter 16 bits, increments, read/write
// - Capture edge loads counter into A
// - Buffer mode moves old A to C
// - Flags clear by zero write after read
// - Capture enable b0 raises request
// - Overflow enable b3 raises request
// - Start bit b7 runs or holds count
// - Level field sets priority, 0 disables
// - Read-only b3 shows pending request
// - Filter bit b2 filters capture pin
// - Filter clock 11 uses count clock
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "capture_timer_regs.vh"
module capture_timer (
   input  wire        core_clk,
   input  wire        srst,
   input  wire [3:0]  addr,
   input  wire [7:0]  wdata,
   input  wire        wr_en,
   input  wire        rd_en,
   output reg  [7:0]  rdata,
   input  wire        capture_input_pin_a,
   input  wire        ext_clk,
   output reg         irq_req,
   output reg  [2:0]  irq_level
);

////////////////////////////////////////////////////////////////////////////////
// Registers
reg  [7:0]  timer_control;
reg  [3:0]  capture_io_control;
reg  [15:0] capture_timer_counter;
reg  [15:0] general_a;
reg  [15:0] general_c_buffer;
reg         capture_flag_a;
reg         overflow_flag;
reg         capt_seen_set;
reg         ovf_seen_set;
reg  [7:0]  source_enables;
reg  [7:0]  timer_mode;
reg  [2:0]  int_level;
reg  [7:0]  cnt_hi_latch;
reg  [7:0]  a_hi_latch;
reg  [7:0]  c_hi_latch;
reg  [5:0]  osc_acc;
reg         osc_tick;
reg         ext_d;
reg  [2:0]  filt_sh;
reg         filt_out;
reg         pin_d;
wire        irq_pend;

wire [2:0] count_source_sel  = timer_control[`CTL_SRC_LSB +: 3];
wire [1:0] ext_edge_sel      = timer_control[`CTL_EDGE_LSB +: 2];
wire [1:0] clear_source_sel  = timer_control[`CTL_CLR_LSB +: 2];
wire [1:0] chan_a_edge_ctl   = capture_io_control[`IO_EDGE_LSB +: 2];
wire       chan_a_mode_sel   = capture_io_control[`IO_MODE_BIT];
wire       buffer_enable_a   = capture_io_control[`IO_BUF_BIT];
wire       input_filter_enable_a = timer_mode[`MODE_FILTER_BIT];
wire [1:0] filter_clock_sel  = timer_mode[`MODE_FCLK_LSB +: 2];
wire       count_start_bit   = timer_mode[`MODE_START_BIT];

////////////////////////////////////////////////////////////////////////////////
// Count clock enables
// 40 MHz from 125 MHz by phase accumulation: one tick per 25 ns on average
wire [5:0] osc_sum = osc_acc + 6'd`CORE_PERIOD_NS;
always @(posedge core_clk) begin
   if (srst) begin
      osc_acc  <= 6'h00;
      osc_tick <= 1'b0;
   end else if (osc_sum >= 6'd`OSC_PERIOD_NS) begin
      osc_acc  <= osc_sum - 6'd`OSC_PERIOD_NS;
      osc_tick <= 1'b1;
   end else begin
      osc_acc  <= osc_sum;
      osc_tick <= 1'b0;
   end
end

// Previous level of the external clock, for its edge detector
always @(posedge core_clk) begin
   if (srst)
      ext_d <= 1'b0;
   else
      ext_d <= ext_clk;
end

reg ext_tick;
always @* begin
   case (ext_edge_sel)
      2'h0:           ext_tick = ext_clk & ~ext_d;
      2'h1:           ext_tick = ~ext_clk & ext_d;
      `EXT_EDGE_BOTH: ext_tick = ext_clk ^ ext_d;
      default:        ext_tick = 1'b0;
   endcase
end

// Other source codes fall back to the external clock input
wire count_tick = (count_source_sel == `SRC_OSC_40MHZ) ? osc_tick : ext_tick;

////////////////////////////////////////////////////////////////////////////////
// Input filter and edge detection
// Filter takes the count clock when selected, otherwise the core clock
wire filt_en = (filter_clock_sel == `FCLK_COUNT_SRC) ? count_tick : 1'b1;
wire [2:0] filt_in = {filt_sh[1:0], capture_input_pin_a};

// Sample chain of the filter, one stage per bit
genvar gi;
generate
   for (gi = 0; gi < `FILTER_SAMPLES; gi = gi + 1) begin : g_filt
      always @(posedge core_clk) begin
         if (srst)
            filt_sh[gi] <= 1'b0;
         else if (filt_en)
            filt_sh[gi] <= filt_in[gi];
      end
   end
endgenerate

// Output changes only when all samples agree, so short glitches are dropped
always @(posedge core_clk) begin
   if (srst)
      filt_out <= 1'b0;
   else if (filt_en) begin
      if (filt_sh == 3'h7)
         filt_out <= 1'b1;
      else if (filt_sh == 3'h0)
         filt_out <= 1'b0;
   end
end

wire pin_val = input_filter_enable_a ? filt_out : capture_input_pin_a;
// Starts at the idle low level so reset gives no false edge
always @(posedge core_clk) begin
   if (srst)
      pin_d <= 1'b0;
   else
      pin_d <= pin_val;
end

reg cap_edge;
always @* begin
   case (chan_a_edge_ctl)
      `EDGE_RISING:  cap_edge = pin_val & ~pin_d;
      `EDGE_FALLING: cap_edge = ~pin_val & pin_d;
      `EDGE_BOTH:    cap_edge = pin_val ^ pin_d;
      default:       cap_edge = 1'b0;
   endcase
end
wire capture = cap_edge & chan_a_mode_sel;

////////////////////////////////////////////////////////////////////////////////
// Register access decode
wire wr_ctl  = wr_en && addr == `ADDR_TIMER_CONTROL;
wire wr_io   = wr_en && addr == `ADDR_CAPTURE_IO_CONTROL;
wire wr_cnt  = wr_en && addr == `ADDR_COUNT_VALUE;
wire wr_cnth = wr_en && addr == `ADDR_COUNT_HIGH;
wire wr_a    = wr_en && addr == `ADDR_GENERAL_A;
wire wr_c    = wr_en && addr == `ADDR_GENERAL_C_BUFFER;
wire wr_flg  = wr_en && addr == `ADDR_TIMER_FLAGS;
wire wr_ien  = wr_en && addr == `ADDR_SOURCE_ENABLES;
wire wr_mode = wr_en && addr == `ADDR_TIMER_MODE;
wire wr_ic   = wr_en && addr == `ADDR_INT_LEVEL_CONTROL;
wire rd_flg  = rd_en && addr == `ADDR_TIMER_FLAGS;

wire count_step = count_start_bit & count_tick;
wire wrap       = count_step && capture_timer_counter == `CNT_MAX;
// No automatic clear source is built: codes other than 00 behave as disabled
wire auto_clear = 1'b0 & (clear_source_sel != `CLR_DISABLED);

////////////////////////////////////////////////////////////////////////////////
// Configuration registers
// Each register has its own process so that one write decode drives one target
always @(posedge core_clk) begin
   if (srst)
      timer_control <= `RST_CTRL8;
   else if (wr_ctl)
      timer_control <= wdata;
end

// Only the edge, mode and buffer bits are kept; the upper nibble reads as zero
always @(posedge core_clk) begin
   if (srst)
      capture_io_control <= 4'h0;
   else if (wr_io)
      capture_io_control <= wdata[3:0];
end

always @(posedge core_clk) begin
   if (srst)
      source_enables <= `RST_CTRL8;
   else if (wr_ien)
      source_enables <= wdata;
end

always @(posedge core_clk) begin
   if (srst)
      timer_mode <= `RST_CTRL8;
   else if (wr_mode)
      timer_mode <= wdata;
end

// Priority level; the pending bit beside it is read-only
always @(posedge core_clk) begin
   if (srst)
      int_level <= 3'h0;
   else if (wr_ic)
      int_level <= wdata[2:0];
end

////////////////////////////////////////////////////////////////////////////////
// Counter
// The high byte is staged first; the low-byte write commits both at once,
// so the counter never holds a half-written value
always @(posedge core_clk) begin
   if (srst)
      cnt_hi_latch <= 8'h00;
   else if (wr_cnth)
      cnt_hi_latch <= wdata;
end

// A software write beats counting in the same cycle
always @(posedge core_clk) begin
   if (srst)
      capture_timer_counter <= `RST_DATA16;
   else if (wr_cnt)
      capture_timer_counter <= {cnt_hi_latch, wdata};
   else if (auto_clear)
      capture_timer_counter <= `RST_DATA16;
   else if (count_step)
      capture_timer_counter <= capture_timer_counter + 16'h0001;
end

////////////////////////////////////////////////////////////////////////////////
// Capture registers
// A capture beats a software write in the same cycle
always @(posedge core_clk) begin
   if (srst)
      general_a <= `RST_DATA16;
   else if (capture)
      general_a <= capture_timer_counter;
   else if (wr_a)
      general_a <= {a_hi_latch, wdata};
end

// In buffer mode the old value of A moves here on the capture edge that loads A
always @(posedge core_clk) begin
   if (srst)
      general_c_buffer <= `RST_DATA16;
   else if (capture && buffer_enable_a)
      general_c_buffer <= general_a;
   else if (wr_c && !capture)
      general_c_buffer <= {c_hi_latch, wdata};
end

// A and C have no high-byte staging: their upper bytes load as zero
always @(posedge core_clk) begin
   if (srst) begin
      a_hi_latch <= 8'h00;
      c_hi_latch <= 8'h00;
   end else begin
      a_hi_latch <= 8'h00;
      c_hi_latch <= 8'h00;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read data
// Stands for one cycle after the read strobe and is zero at every other time
reg [7:0] next_rdata;
always @* begin
   next_rdata = 8'h00;
   if (rd_en) begin
      case (addr)
         `ADDR_TIMER_CONTROL:      next_rdata = timer_control;
         `ADDR_CAPTURE_IO_CONTROL: next_rdata = {4'h0, capture_io_control};
         `ADDR_COUNT_VALUE:        next_rdata = capture_timer_counter[7:0];
         `ADDR_GENERAL_A:          next_rdata = general_a[7:0];
         `ADDR_GENERAL_C_BUFFER:   next_rdata = general_c_buffer[7:0];
         `ADDR_TIMER_FLAGS:        next_rdata = {4'h0, overflow_flag, 2'h0, capture_flag_a};
         `ADDR_SOURCE_ENABLES:     next_rdata = source_enables;
         `ADDR_TIMER_MODE:         next_rdata = timer_mode;
         `ADDR_INT_LEVEL_CONTROL:  next_rdata = {4'h0, irq_pend, int_level};
         `ADDR_COUNT_HIGH:         next_rdata = capture_timer_counter[15:8];
         `ADDR_GENERAL_A_HIGH:     next_rdata = general_a[15:8];
         `ADDR_GENERAL_C_HIGH:     next_rdata = general_c_buffer[15:8];
         default:                  next_rdata = 8'h00;
      endcase
   end
end

always @(posedge core_clk) begin
   if (srst)
      rdata <= 8'h00;
   else
      rdata <= next_rdata;
end

////////////////////////////////////////////////////////////////////////////////
// Status flags and interrupt request
// A zero write clears a flag only if it was read as set; a new event wins over it
wire capt_clr = wr_flg && !wdata[`FLAG_CAPT_BIT] && capt_seen_set;
wire ovf_clr  = wr_flg && !wdata[`FLAG_OVF_BIT] && ovf_seen_set;

always @(posedge core_clk) begin
   if (srst)
      capture_flag_a <= 1'b0;
   else if (capture)
      capture_flag_a <= 1'b1;
   else if (capt_clr)
      capture_flag_a <= 1'b0;
end

always @(posedge core_clk) begin
   if (srst)
      overflow_flag <= 1'b0;
   else if (wrap)
      overflow_flag <= 1'b1;
   else if (ovf_clr)
      overflow_flag <= 1'b0;
end

// A clear is armed only by a read that saw the flag set
always @(posedge core_clk) begin
   if (srst)
      capt_seen_set <= 1'b0;
   else if (capt_clr)
      capt_seen_set <= 1'b0;
   else if (rd_flg && capture_flag_a)
      capt_seen_set <= 1'b1;
end

always @(posedge core_clk) begin
   if (srst)
      ovf_seen_set <= 1'b0;
   else if (ovf_clr)
      ovf_seen_set <= 1'b0;
   else if (rd_flg && overflow_flag)
      ovf_seen_set <= 1'b1;
end

assign irq_pend = (capture_flag_a & source_enables[`IEN_CAPT_BIT])
                | (overflow_flag & source_enables[`IEN_OVF_BIT]);

// Level 0 masks the request
always @(posedge core_clk) begin
   if (srst)
      irq_req <= 1'b0;
   else
      irq_req <= irq_pend && int_level != 3'h0;
end

always @(posedge core_clk) begin
   if (srst)
      irq_level <= 3'h0;
   else
      irq_level <= int_level;
end

endmodule

/* File: test/pulse_source.sv */
// Model of the external signal whose pulse width is measured
`timescale 1ns/10ps
module pulse_source (
   input  wire core_clk,
   output reg  pin_a,
   output reg  ext_clk
);
   initial begin
      pin_a = 1'b0;
      ext_clk = 1'b0;
   end
   // One high pulse, width in core clock cycles
   task pulse(input int width);
      begin
         @(posedge core_clk);
         pin_a <= 1'b1;
         repeat (width) @(posedge core_clk);
         pin_a <= 1'b0;
      end
   endtask
   // Toggles the external count clock n times, two core cycles per level
   task ext_edges(input int n);
      begin
         repeat (n) begin
            @(posedge core_clk);
            ext_clk <= ~ext_clk;
            @(posedge core_clk);
         end
      end
   endtask
endmodule

/* File: test/capture_timer_checker.sv */
// Port assertions for the capture timer
`timescale 1ns/10ps
module capture_timer_checker (
   input wire       core_clk,
   input wire       srst,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr_en,
   input wire       rd_en,
   input wire [7:0] rdata,
   input wire       capture_input_pin_a,
   input wire       ext_clk,
   input wire       irq_req,
   input wire [2:0] irq_level
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence mode_wr_rd;
      wr_en && addr == 4'h7 ##1 rd_en && addr == 4'h7 && !wr_en;
   endsequence
   sequence lvl_wr;
      wr_en && addr == 4'h8 ##1 !wr_en [*2];
   endsequence
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("rdata not zero outside read");
   mode_back_a: assert property (mode_wr_rd |=> (rdata & 8'hb4) == ($past(wdata, 2) & 8'hb4))
      else $error("mode readback wrong");
   level_copy_a: assert property (lvl_wr |-> irq_level == $past(wdata[2:0], 2))
      else $error("level output wrong");
   level_off_a: assert property (irq_level == 3'h0 && $past(irq_level) == 3'h0 |-> !irq_req)
      else $error("request at level 0");
   unmapped_zero_a: assert property (rd_en && addr > 4'hb |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   level_read_a: assert property (rd_en && addr == 4'h8 |=> rdata[2:0] == $past(irq_level))
      else $error("level read wrong");
   req_drop_a: assert property ($fell(irq_req) |-> $past(wr_en) || $past(wr_en, 2) || $past(wr_en, 3))
      else $error("request dropped without write");
   req_rise_a: assert property ($rose(irq_req) |-> irq_level != 3'h0)
      else $error("request raised at level 0");
endmodule

/* File: test/capture_timer_tb.sv */
// Self-checking bench for the capture timer
`timescale 1ns/10ps
module capture_timer_tb;
   reg        core_clk, srst, wr_en, rd_en;
   reg  [3:0] addr;
   reg  [7:0] wdata;
   wire [7:0] rdata;
   wire       pin_a, ext_clk, irq_req;
   wire [2:0] irq_level;
   int        err_total, checked, cyc;
   reg  [15:0] va, vc;
   reg  [7:0]  b;
   capture_timer u_capture_timer (.core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .capture_input_pin_a(pin_a),
      .ext_clk(ext_clk), .irq_req(irq_req), .irq_level(irq_level));
   pulse_source u_pulse_source (.core_clk(core_clk), .pin_a(pin_a), .ext_clk(ext_clk));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         conclude;
      end
   end
   ////////////////////////////////////////////////////////////////////
   task conclude;
      begin
         $display("errors %0d checks %0d", err_total, checked);
         if (err_total == 0 && checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task cmp_in(input [15:0] got, input [15:0] lo, input [15:0] hi);
      begin
         checked = checked + 1;
         if (!(got >= lo && got <= hi)) begin
            err_total = err_total + 1;
            $display("BAD %0t got %h outside range", $time, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge core_clk);
         addr <= a;
         wdata <= d;
         wr_en <= 1'b1;
         @(posedge core_clk);
         wr_en <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, output [7:0] d);
      begin
         @(posedge core_clk);
         addr <= a;
         rd_en <= 1'b1;
         @(posedge core_clk);
         rd_en <= 1'b0;
         #1 d = rdata;
      end
   endtask
   task wr_rd(input [3:0] a, input [7:0] d, output [7:0] q);
      begin
         @(posedge core_clk);
         addr <= a;
         wdata <= d;
         wr_en <= 1'b1;
         @(posedge core_clk);
         wr_en <= 1'b0;
         rd_en <= 1'b1;
         @(posedge core_clk);
         rd_en <= 1'b0;
         #1 q = rdata;
      end
   endtask
   task rd16(input [3:0] lo, input [3:0] hi, output [15:0] v);
      begin
         rd(lo, v[7:0]);
         rd(hi, v[15:8]);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   task t_setup;
      begin
         wr(4'h9, 8'h00);
         wr(4'h2, 8'h00);
         wr(4'h3, 8'h00);
         wr(4'h4, 8'h00);
         wr(4'h0, 8'h16);
         wr(4'h1, 8'h0e);
         rd(4'h0, b);
         cmp(b, 16'h0016);
         rd(4'h1, b);
         cmp(b, 16'h000e);
         rd(4'hf, b);
         cmp(b, 16'h0000);
         repeat (20) @(posedge core_clk);
         rd16(4'h2, 4'h9, va);
         cmp(va, 16'h0000);
      end
   endtask
   task t_capture;
      begin
         wr(4'h6, 8'h09);
         wr_rd(4'h7, 8'h80, b);
         cmp(b, 16'h0080);
         wr(4'h8, 8'h01);
         u_pulse_source.pulse(100);
         repeat (10) @(posedge core_clk);
         rd16(4'h3, 4'ha, va);
         rd16(4'h4, 4'hb, vc);
         cmp_in(vc, 16'h0001, 16'h0100);
         cmp_in(va - vc, 16'd30, 16'd34);
         cmp(irq_req, 1'b1);
         rd(4'h8, b);
         cmp(b, 16'h0009);
      end
   endtask
   task t_clear;
      begin
         wr(4'h5, 8'h0e);
         rd(4'h5, b);
         cmp(b[0], 1'b1);
         wr(4'h5, 8'h0e);
         wr(4'h5, 8'h0f);
         rd(4'h5, b);
         cmp(b[0], 1'b0);
         cmp(irq_req, 1'b0);
      end
   endtask
   task t_ovf;
      begin
         wr(4'h9, 8'hff);
         wr(4'h2, 8'hf0);
         repeat (80) @(posedge core_clk);
         rd(4'h5, b);
         cmp(b[3], 1'b1);
         cmp(irq_req, 1'b1);
         rd(4'h9, b);
         cmp(b, 16'h0000);
         wr(4'h8, 8'h00);
         repeat (3) @(posedge core_clk);
         cmp(irq_req, 1'b0);
      end
   endtask
   task t_ext;
      begin
         wr(4'h0, 8'h10);
         wr(4'h9, 8'h00);
         wr(4'h2, 8'h00);
         u_pulse_source.ext_edges(10);
         repeat (3) @(posedge core_clk);
         rd16(4'h2, 4'h9, va);
         cmp(va, 16'h000a);
      end
   endtask
   initial begin
      err_total = 0;
      checked = 0;
      cyc = 0;
      srst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      t_setup;
      t_capture;
      t_clear;
      t_ovf;
      t_ext;
      conclude;
   end
endmodule
bind capture_timer capture_timer_checker u_capture_timer_checker (.core_clk(core_clk),
   .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .capture_input_pin_a(capture_input_pin_a), .ext_clk(ext_clk), .irq_req(irq_req),
   .irq_level(irq_level));
